//--- hw/evi_pkg.sv
// Package for the eight level vectored interrupt logic
package evi_pkg;
	localparam int NUM_SRC = 16;
	localparam int NUM_LVL = 8;
	// Register index map
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_PRIO = 4'h2;
	localparam logic [3:0] ADDR_REQ = 4'h3;
	localparam logic [3:0] ADDR_PEND_LO = 4'h4;
	localparam logic [3:0] ADDR_PEND_HI = 4'h5;
	localparam logic [3:0] ADDR_SEN_LO = 4'h6;
	localparam logic [3:0] ADDR_SEN_HI = 4'h7;
	localparam logic [3:0] ADDR_EDGE_LO = 4'h8;
	localparam logic [3:0] ADDR_IST = 4'h9;
	localparam logic [3:0] ADDR_IMSK = 4'hA;
	localparam logic [3:0] ADDR_VEC = 4'hB;
	localparam int GIE_BIT = 0;
	localparam logic [15:0] RESET_VECTOR = 16'h0100;
	localparam logic [15:0] WDOG_VECTOR = 16'h0100;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	// Source to level map, sources in ascending vector order
	localparam logic [2:0] SRC_LVL [16] = '{3'd0, 3'd1, 3'd1, 3'd2, 3'd2, 3'd2, 3'd2, 3'd3, 3'd3, 3'd3,
		3'd3, 3'd4, 3'd5, 3'd6, 3'd7, 3'd7};
	localparam logic [7:0] SRC_VEC [16] = '{8'hBE, 8'hC0, 8'hC2, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCE, 8'hD0,
		8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hDA, 8'hDC, 8'hDE};
	// Sources whose pending bit hardware clears on grant
	localparam logic [15:0] HW_CLEAR = 16'h007F;
	// First pin source index
	localparam int PIN_BASE = 7;
	// Interrupt status bits
	localparam int IST_GRANT = 0;
	localparam int IST_WDOG = 1;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} evi_bus_t;
	typedef struct packed {
		logic grant;
		logic [7:0] vector;
		logic [2:0] level;
	} evi_ack_t;
endpackage : evi_pkg

//--- hw/evi_ctrl.sv
// Eight level vectored interrupt controller
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module evi_ctrl
	import evi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire evi_pkg::evi_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [15:0] src_event,
	input wire logic [3:0] pin_in,
	input wire logic wdog_overflow,
	input wire logic cpu_ready,
	input wire logic [7:0] vec_byte,
	input wire logic gie_on,
	input wire logic gie_off,
	output logic [7:0] vec_addr,
	output logic vec_rd,
	output logic stack_push,
	output logic [15:0] pc_load,
	output logic pc_load_en,
	output logic core_reset,
	output logic irq
);
	/****************************/
	/* Registers                */
	/****************************/
	logic [7:0] system_mode_reg, level_mask_reg, level_priority_reg, ist, imsk;
	logic [15:0] pend, sen;
	logic [3:0] edge_sel;
	logic [3:0] p1, p2, p3;
	logic [7:0] vec_hi, gnt_vec;
	logic [3:0] gnt_src;
	typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_PUSH, ST_FETCH_HI, ST_FETCH_LO, ST_LOAD} evi_state_t;
	evi_state_t state;
	logic wdog_s1, wdog_s2, wdog_s3;

	/****************************/
	/* Decode                   */
	/****************************/
	// Level rank: a lower rank wins; base order from priority register
	function automatic logic [3:0] lvl_rank(input logic [2:0] l, input logic [7:0] p);
		logic [2:0] r;
		r = l;
		if (p[0]) begin
			r = {l[2:1], ~l[0]};
		end
		if (p[1]) begin
			r = {~l[2], l[1:0]};
		end
		if (p[2]) begin
			r = 3'd7 - l;
		end
		lvl_rank = {1'b0, r};
	endfunction : lvl_rank

	wire [15:0] active = pend & sen;
	wire [7:0] req_lvl;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LVL; gi++) begin : g_lvl
			wire [15:0] hit;
			for (genvar s = 0; s < NUM_SRC; s++) begin : g_s
				assign hit[s] = active[s] && (SRC_LVL[s] == 3'(gi));
			end
			assign req_lvl[gi] = |hit;
		end
	endgenerate
	wire [7:0] eligible = req_lvl & level_mask_reg;

	logic [2:0] win_lvl;
	logic [3:0] win_src;
	logic win_any;
	always_comb begin
		logic [3:0] best;
		best = 4'hF;
		win_lvl = 3'd0;
		win_any = 1'b0;
		for (int l = 0; l < NUM_LVL; l++) begin
			if (eligible[l] && lvl_rank(3'(l), level_priority_reg) < best) begin
				best = lvl_rank(3'(l), level_priority_reg);
				win_lvl = 3'(l);
				win_any = 1'b1;
			end
		end
		win_src = 4'd0;
		for (int s = NUM_SRC - 1; s >= 0; s--) begin
			if (active[s] && SRC_LVL[s] == win_lvl) begin
				win_src = 4'(s);
			end
		end
	end
	/****************************/
	/* Pin edges                */
	/****************************/
	// Two stage sync, third stage for edge compare
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			p1 <= 4'h0;
			p2 <= 4'h0;
			p3 <= 4'h0;
			wdog_s1 <= 1'b0;
			wdog_s2 <= 1'b0;
			wdog_s3 <= 1'b0;
		end else begin
			p1 <= pin_in;
			p2 <= p1;
			p3 <= p2;
			wdog_s1 <= wdog_overflow;
			wdog_s2 <= wdog_s1;
			wdog_s3 <= wdog_s2;
		end
	end
	wire [3:0] pin_edge = (edge_sel & p2 & ~p3) | (~edge_sel & ~p2 & p3);
	wire wdog_rise = wdog_s2 & ~wdog_s3;
	// Watchdog reset outranks a grant, so no pending bit is cleared unserved
	wire take = win_any && system_mode_reg[GIE_BIT] && state == ST_IDLE && !wdog_rise;
	wire [15:0] set_ev = src_event | {5'h00, pin_edge, 7'h00};
	wire [15:0] hw_clr = (take ? (16'h0001 << win_src) : 16'h0000) & HW_CLEAR;
	wire wr_pend_lo = bus.wr && bus.addr == ADDR_PEND_LO;
	wire wr_pend_hi = bus.wr && bus.addr == ADDR_PEND_HI;
	wire [15:0] sw_clr = {wr_pend_hi ? bus.wdata : 8'h00, wr_pend_lo ? bus.wdata : 8'h00};
	wire [15:0] next_pend = (pend & ~(sw_clr | hw_clr)) | set_ev; // set wins over clear
	wire [7:0] next_ist = (ist & ~((bus.wr && bus.addr == ADDR_IST) ? bus.wdata : 8'h00)) |
		{6'h00, wdog_rise, take};

	/****************************/
	/* Bus and state            */
	/****************************/
	logic [7:0] rd_mux;
	always_comb begin
		case (bus.addr)
			ADDR_MODE: rd_mux = system_mode_reg;
			ADDR_MASK: rd_mux = level_mask_reg;
			ADDR_PRIO: rd_mux = level_priority_reg;
			ADDR_REQ: rd_mux = req_lvl;
			ADDR_PEND_LO: rd_mux = pend[7:0];
			ADDR_PEND_HI: rd_mux = pend[15:8];
			ADDR_SEN_LO: rd_mux = sen[7:0];
			ADDR_SEN_HI: rd_mux = sen[15:8];
			ADDR_EDGE_LO: rd_mux = {4'h0, edge_sel};
			ADDR_IST: rd_mux = ist;
			ADDR_IMSK: rd_mux = imsk;
			ADDR_VEC: rd_mux = gnt_vec;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			system_mode_reg <= RESET_ZERO;
			level_mask_reg <= RESET_ZERO;
			level_priority_reg <= RESET_ZERO;
			imsk <= RESET_ZERO;
			ist <= RESET_ZERO;
			pend <= 16'h0000;
			sen <= 16'h0000;
			edge_sel <= 4'h0;
			rdata <= RESET_ZERO;
			irq <= 1'b0;
		end else begin
			rdata <= bus.rd ? rd_mux : 8'h00;
			pend <= next_pend;
			ist <= next_ist;
			irq <= |(next_ist & imsk);
			if (take || gie_off || wdog_rise) begin
				system_mode_reg[GIE_BIT] <= 1'b0;
			end else if (gie_on) begin
				system_mode_reg[GIE_BIT] <= 1'b1;
			end else if (bus.wr && bus.addr == ADDR_MODE) begin
				system_mode_reg <= bus.wdata;
			end
			if (bus.wr) begin
				case (bus.addr)
					ADDR_MASK: level_mask_reg <= bus.wdata;
					ADDR_PRIO: level_priority_reg <= bus.wdata;
					ADDR_SEN_LO: sen[7:0] <= bus.wdata;
					ADDR_SEN_HI: sen[15:8] <= bus.wdata;
					ADDR_EDGE_LO: edge_sel <= bus.wdata[3:0];
					ADDR_IMSK: imsk <= bus.wdata;
					default: ;
				endcase
			end
		end
	end

	// Vector fetch sequencer; reset vector is a direct load, not a table entry
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_RESET;
			vec_addr <= 8'h00;
			vec_rd <= 1'b0;
			stack_push <= 1'b0;
			pc_load <= 16'h0000;
			pc_load_en <= 1'b0;
			core_reset <= 1'b0;
			vec_hi <= 8'h00;
			gnt_vec <= 8'h00;
			gnt_src <= 4'h0;
		end else begin
			vec_rd <= 1'b0;
			stack_push <= 1'b0;
			pc_load_en <= 1'b0;
			core_reset <= 1'b0;
			case (state)
				ST_RESET: begin
					pc_load <= RESET_VECTOR;
					pc_load_en <= 1'b1;
					state <= ST_IDLE;
				end
				ST_IDLE: begin
					if (wdog_rise) begin
						core_reset <= 1'b1;
						state <= ST_RESET;
					end else if (take) begin
						gnt_src <= win_src;
						gnt_vec <= SRC_VEC[win_src];
						stack_push <= 1'b1;
						state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					if (cpu_ready) begin
						vec_addr <= gnt_vec;
						vec_rd <= 1'b1;
						state <= ST_FETCH_HI;
					end
				end
				ST_FETCH_HI: begin
					vec_hi <= vec_byte;
					vec_addr <= gnt_vec + 8'h01;
					vec_rd <= 1'b1;
					state <= ST_FETCH_LO;
				end
				ST_FETCH_LO: begin
					pc_load <= {vec_hi, vec_byte};
					pc_load_en <= 1'b1;
					state <= ST_LOAD;
				end
				ST_LOAD: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	/****************************/
	/* Assertions               */
	/****************************/
	property p_grant_off;
		@(posedge ref_clk) disable iff (!rst_b) take |=> !system_mode_reg[GIE_BIT] && stack_push;
	endproperty
	a_grant_off: assert property (p_grant_off) else $error("grant left interrupts on");
	sequence s_fetch;
		vec_rd ##1 vec_rd ##1 pc_load_en;
	endsequence
	property p_fetch;
		@(posedge ref_clk) disable iff (!rst_b) (state == ST_PUSH && cpu_ready) |=> s_fetch;
	endproperty
	a_fetch: assert property (p_fetch) else $error("vector fetch sequence broken");
	property p_mask;
		@(posedge ref_clk) disable iff (!rst_b) take |-> level_mask_reg[win_lvl] && req_lvl[win_lvl];
	endproperty
	a_mask: assert property (p_mask) else $error("masked level granted");
	property p_gie;
		@(posedge ref_clk) disable iff (!rst_b) take |-> system_mode_reg[GIE_BIT];
	endproperty
	a_gie: assert property (p_gie) else $error("grant while disabled");
	property p_hwclr;
		@(posedge ref_clk) disable iff (!rst_b) (take && HW_CLEAR[win_src] && !set_ev[win_src]) |=> !pend[gnt_src];
	endproperty
	a_hwclr: assert property (p_hwclr) else $error("timer pending not cleared");
	property p_order;
		@(posedge ref_clk) disable iff (!rst_b) take |-> !(active[win_src] == 1'b0);
	endproperty
	a_order: assert property (p_order) else $error("winner not active");
	property p_uart;
		@(posedge ref_clk) disable iff (!rst_b) (take && active[14] && active[15]) |-> win_src == 4'd14;
	endproperty
	a_uart: assert property (p_uart) else $error("uart transmit beat receive");
	property p_wdt;
		@(posedge ref_clk) disable iff (!rst_b) (wdog_rise && state == ST_IDLE) |=> core_reset ##1 (pc_load_en && pc_load == WDOG_VECTOR);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset not taken");
	property p_req;
		@(posedge ref_clk) disable iff (!rst_b) (bus.rd && bus.addr == ADDR_REQ) |=> rdata == $past(req_lvl);
	endproperty
	a_req: assert property (p_req) else $error("level request wrong");
endmodule : evi_ctrl
`default_nettype wire

//--- sim/evi_cpu_model.sv
// CPU core model: stacks, then answers vector byte fetches
`timescale 1ns/1ps
`default_nettype none
module evi_cpu_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic [7:0] vec_addr,
	input wire logic vec_rd,
	input wire logic stack_push,
	input wire logic pc_load_en,
	output logic cpu_ready,
	output logic [7:0] vec_byte
);
	// ****
	// Fetch side
	// ****
	logic busy;
	logic tog;
	logic [2:0] dly;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			tog <= 1'b0;
			dly <= 3'h0;
		end else begin
			tog <= ~tog;
			if (stack_push) begin
				busy <= 1'b1;
				dly <= slow ? 3'h4 : 3'h0;
			end else if (pc_load_en) begin
				busy <= 1'b0;
			end else if (dly != 3'h0) begin
				dly <= dly - 3'h1;
			end
		end
	end
	// Ready only once the stack push has had time to land
	assign cpu_ready = busy && dly == 3'h0;
	// Read-only vector store; idle bus toggles so a stale byte never matches
	// Byte answers within the strobe cycle, since the sequencer samples it at that cycle's end
	assign vec_byte = vec_rd ? (vec_addr ^ 8'hA5) : {8{tog}};
endmodule : evi_cpu_model
`default_nettype wire

//--- sim/tb_top.sv
// Testbench for the eight level vectored interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import evi_pkg::*;
	// ****
	// Harness
	// ****
	logic ref_clk, rst_b, cpu_ready, slow, wdog, gon, goff, vec_rd, stack_push, pc_load_en, core_reset, irq;
	logic [7:0] rdata, vec_byte, vec_addr, v;
	logic [15:0] ev, pc_load, pc;
	logic [3:0] pin;
	evi_bus_t bus;
	int failures = 0;
	int checks_done = 0;
	int cyc = 0;
	evi_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .src_event(ev), .pin_in(pin),
		.wdog_overflow(wdog), .cpu_ready(cpu_ready), .vec_byte(vec_byte), .gie_on(gon), .gie_off(goff),
		.vec_addr(vec_addr), .vec_rd(vec_rd), .stack_push(stack_push), .pc_load(pc_load),
		.pc_load_en(pc_load_en), .core_reset(core_reset), .irq(irq));
	evi_cpu_model cpu (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow), .vec_addr(vec_addr), .vec_rd(vec_rd),
		.stack_push(stack_push), .pc_load_en(pc_load_en), .cpu_ready(cpu_ready), .vec_byte(vec_byte));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Hang guard, well above the several hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			failures++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// ****
	// Bus and pulse helpers
	// ****
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk) bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk) bus.rd <= 1'b0;
		@(negedge ref_clk) chk(rdata, e);
	endtask : rd
	task automatic pulse(input logic [15:0] m);
		@(posedge ref_clk) ev <= m;
		@(posedge ref_clk) ev <= 16'h0000;
	endtask : pulse
	task automatic g(input logic on);
		@(posedge ref_clk) begin
			gon <= on;
			goff <= !on;
		end
		@(posedge ref_clk) {gon, goff} <= 2'b00;
	endtask : g
	task automatic clr(input int i);
		wr(i < 8 ? ADDR_PEND_LO : ADDR_PEND_HI, 8'h01 << i[2:0]);
	endtask : clr
	// Expect one grant of vector ve, or none when ve is zero
	task automatic serve(input logic [7:0] ve);
		int p;
		p = 0;
		v = 8'h00;
		pc = 16'h0000;
		for (int i = 0; i < 40 && pc == 16'h0000; i++) begin
			@(negedge ref_clk);
			if (stack_push) p++;
			if (vec_rd && v == 8'h00) v = vec_addr;
			if (pc_load_en) pc = pc_load;
		end
		chk(16'(p), 16'(ve != 8'h00));
		chk(v, ve);
		chk(pc, ve != 8'h00 ? {ve ^ 8'hA5, (ve + 8'h01) ^ 8'hA5} : 16'h0000);
	endtask : serve
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		rd(ADDR_MODE, 8'h00);
		rd(ADDR_MASK, 8'h00);
		wr(ADDR_MASK, 8'hFF);
		wr(ADDR_SEN_LO, 8'hFF);
		wr(ADDR_SEN_HI, 8'hFF);
		wr(ADDR_IMSK, 8'h01);
		wr(4'hC, 8'h55);
		rd(4'hC, 8'h00);
		rd(ADDR_MASK, 8'hFF);
	endtask : t_regs
	task automatic t_order;
		logic [7:0] first, second;
		pulse(16'hC000);
		g(1'b1);
		serve(8'hDC);
		clr(14);
		g(1'b1);
		serve(8'hDE);
		clr(15);
		// Pair swap only shows between neighbour levels, so that step races levels 0 and 1
		for (int k = 0; k < 4; k++) begin
			first = (k == 0) ? 8'hBE : ((k == 2) ? 8'hC0 : 8'hDC);
			second = (k == 0) ? 8'hDC : 8'hBE;
			wr(ADDR_PRIO, (k == 1) ? 8'h04 : ((k == 2) ? 8'h01 : ((k == 3) ? 8'h02 : 8'h00)));
			slow <= k[0];
			pulse((k == 2) ? 16'h0003 : 16'h4001);
			g(1'b1);
			serve(first);
			if (first == 8'hDC) clr(14);
			g(1'b1);
			serve(second);
			if (second == 8'hDC) clr(14);
		end
		wr(ADDR_PRIO, 8'h00);
	endtask : t_order
	task automatic t_gate;
		wr(ADDR_SEN_HI, 8'hBF);
		pulse(16'h4000);
		g(1'b1);
		serve(8'h00);
		wr(ADDR_SEN_HI, 8'hFF);
		serve(8'hDC);
		clr(14);
		wr(ADDR_MASK, 8'h7F);
		pulse(16'h4000);
		g(1'b1);
		serve(8'h00);
		rd(ADDR_REQ, 8'h80);
		wr(ADDR_MASK, 8'hFF);
		serve(8'hDC);
		clr(14);
		g(1'b0);
		pulse(16'h0001);
		serve(8'h00);
		rd(ADDR_MODE, 8'h00);
		g(1'b1);
		serve(8'hBE);
		rd(ADDR_VEC, 8'hBE);
	endtask : t_gate
	task automatic t_src;
		for (int i = 0; i < 16; i++) begin
			pulse(16'h0001 << i);
			g(1'b1);
			serve(8'hBE + 8'(2 * i) + (i > 6 ? 8'h02 : 8'h00));
			rd(i < 8 ? ADDR_PEND_LO : ADDR_PEND_HI, i < 7 ? 8'h00 : 8'h01 << i[2:0]);
			clr(i);
		end
	endtask : t_src
	task automatic pstep(input logic l, input logic [7:0] e);
		@(posedge ref_clk) pin <= {3'b000, l};
		repeat (6) @(posedge ref_clk);
		rd(ADDR_PEND_LO, e);
	endtask : pstep
	task automatic t_pin;
		wr(ADDR_EDGE_LO, 8'h00);
		pstep(1'b1, 8'h00);
		pstep(1'b0, 8'h80);
		clr(7);
		wr(ADDR_EDGE_LO, 8'h01);
		pstep(1'b1, 8'h80);
		clr(7);
		pstep(1'b0, 8'h00);
	endtask : t_pin
	task automatic irqc(input logic e);
		repeat (2) @(negedge ref_clk);
		chk(irq, e);
	endtask : irqc
	task automatic t_irq;
		wr(ADDR_IST, 8'h03);
		irqc(1'b0);
		pulse(16'h0001);
		g(1'b1);
		serve(8'hBE);
		irqc(1'b1);
		wr(ADDR_IMSK, 8'h00);
		irqc(1'b0);
		wr(ADDR_IMSK, 8'h01);
		irqc(1'b1);
		wr(ADDR_IST, 8'h01);
		irqc(1'b0);
	endtask : t_irq
	task automatic t_wdog;
		int n;
		n = 0;
		pc = 16'h0000;
		@(posedge ref_clk) wdog <= 1'b1;
		for (int i = 0; i < 20 && pc == 16'h0000; i++) begin
			@(negedge ref_clk);
			if (core_reset) n++;
			if (pc_load_en && n > 0) pc = pc_load;
		end
		chk(16'(n), 16'h0001);
		chk(pc, 16'h0100);
		@(posedge ref_clk) wdog <= 1'b0;
		rd(ADDR_IST, 8'h02);
	endtask : t_wdog
	initial begin
		rst_b = 1'b0;
		bus = '0;
		ev = 16'h0000;
		pin = 4'h0;
		{wdog, gon, goff, slow} = 4'h0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk) chk(pc_load_en, 1'b1);
		chk(pc_load, 16'h0100);
		t_regs;
		t_order;
		t_gate;
		t_src;
		t_pin;
		t_irq;
		t_wdog;
		test_done;
	end
endmodule : tb_top
`default_nettype wire
